// file: fsup_defines.svh
// Timing constants and reset values of the supply reset supervisor
`ifndef FSUP_DEFINES_SVH
`define FSUP_DEFINES_SVH

// ==========================================================
// Clock
`define FSUP_CLK_PERIOD_NS 50

// ==========================================================
// Times in their own units
`define FSUP_FILTER_TIME_US 25
`define FSUP_RELEASE_DELAY_TIME_US 200
`define FSUP_EN_STARTUP_TIME_US 100
`define FSUP_SOFTSTART_LIMIT_TIME_US 5000

// ==========================================================
// Cycle counts, least times rounded up
`define FSUP_US_TO_CYC(t) \
    (((t) * 1000 + `FSUP_CLK_PERIOD_NS - 1) / `FSUP_CLK_PERIOD_NS)
`define FSUP_FILTER_CYC `FSUP_US_TO_CYC(`FSUP_FILTER_TIME_US)
`define FSUP_RELEASE_CYC `FSUP_US_TO_CYC(`FSUP_RELEASE_DELAY_TIME_US)
`define FSUP_EN_CYC `FSUP_US_TO_CYC(`FSUP_EN_STARTUP_TIME_US)
`define FSUP_SS_CYC `FSUP_US_TO_CYC(`FSUP_SOFTSTART_LIMIT_TIME_US)

// ==========================================================
// Reset values
`define FSUP_RST_FAULT 1'b1
`define FSUP_RST_RESET_OE 1'b1

`endif

// file: fsup_pkg.sv
// Types of the supply reset supervisor
package fsup_pkg;
    typedef enum logic [1:0] {
        FSUP_ST_FAULT = 2'b00,
        FSUP_ST_DELAY = 2'b01,
        FSUP_ST_READY = 2'b10
    } fsup_state_e;
endpackage

// file: fsup_filt_if.sv
// Comparator conditions and qualified fault of one filtered monitor
`timescale 1ns/1ps
interface fsup_filt_if;
    logic set_cond;
    logic clr_cond;
    logic fault;
    modport filt (input set_cond, input clr_cond, output fault);
    modport user (output set_cond, output clr_cond, input fault);
endinterface

// file: fsup_filter.sv
// Persistence filter that sets and clears one fault
`timescale 1ns/1ps
`include "fsup_defines.svh"
module fsup_filter #(
    parameter int FILT_CYC = `FSUP_FILTER_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Conditions and fault
    fsup_filt_if.filt fi
);
    localparam int CW = $clog2(FILT_CYC + 1);
    localparam logic [CW-1:0] CMAX = CW'(FILT_CYC);

    logic [CW-1:0] cnt_q, cnt_d;
    logic fault_q, fault_d;
    logic cond;

    // ==========================================================
    // Filter
    always_comb begin
        cond = fault_q ? fi.clr_cond : fi.set_cond;
        fault_d = fault_q;
        cnt_d = '0;
        if (cond) begin
            // Longer than the filter time, so one past the count
            if (cnt_q == CMAX) begin
                fault_d = !fault_q;
            end else begin
                cnt_d = cnt_q + CW'(1);
            end
        end
        // Dropout leaves cnt_d at zero
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            fault_q <= `FSUP_RST_FAULT;
        end else begin
            cnt_q <= cnt_d;
            fault_q <= fault_d;
        end
    end

    assign fi.fault = fault_q;

    // ==========================================================
    // Checks
    filt_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(fault_q) |-> $past(fi.set_cond) && $past(cnt_q) == CMAX)
        else $error("fault set without full persistence");
    filt_clr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(fault_q) |-> $past(fi.clr_cond) && $past(cnt_q) == CMAX)
        else $error("fault cleared without full persistence");
    filt_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !cond |=> cnt_q == '0)
        else $error("filter count not restarted");
endmodule

// file: fsup_top.sv
// Supply reset supervisor: fault collection, release delay, soft start
`timescale 1ns/1ps
`include "fsup_defines.svh"
module fsup_top #(
    parameter int FILT_CYC = `FSUP_FILTER_CYC,
    parameter int REL_CYC = `FSUP_RELEASE_CYC,
    parameter int EN_CYC = `FSUP_EN_CYC,
    parameter int SS_CYC = `FSUP_SS_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Feedback comparators
    input wire logic fb_below_uv,
    input wire logic fb_above_uv_hyst,
    input wire logic fb_above_ov,
    input wire logic fb_below_ov_hyst,
    // Temperature comparators
    input wire logic overtemp_trip,
    input wire logic overtemp_recovered,
    // Enable and supplies
    input wire logic enable,
    input wire logic vcc_below_lockout_hyst,
    input wire logic vcc_above_lockout,
    input wire logic supply_input_ok,
    // Soft start
    input wire logic output_full,
    // Open-drain reset pin
    output logic reset_o,
    output logic reset_oe,
    // Power stage controls
    output logic switching_off,
    output logic sw_pulldown_en,
    output logic softstart_active
);
    localparam int RW = $clog2(REL_CYC + 1);
    localparam int EW = $clog2(EN_CYC + 1);
    localparam int SSW = $clog2(SS_CYC + 1);
    localparam logic [RW-1:0] RMAX = RW'(REL_CYC);
    localparam logic [EW-1:0] EMAX = EW'(EN_CYC);
    localparam logic [SSW-1:0] SMAX = SSW'(SS_CYC);

    // ==========================================================
    // Filtered feedback monitors
    fsup_filt_if uv_if ();
    fsup_filt_if ov_if ();

    assign uv_if.set_cond = fb_below_uv;
    assign uv_if.clr_cond = fb_above_uv_hyst;
    assign ov_if.set_cond = fb_above_ov;
    assign ov_if.clr_cond = fb_below_ov_hyst;

    fsup_filter #(.FILT_CYC(FILT_CYC)) u_uv_filt (
        .mclk(mclk),
        .rst_n(rst_n),
        .fi(uv_if)
    );

    fsup_filter #(.FILT_CYC(FILT_CYC)) u_ov_filt (
        .mclk(mclk),
        .rst_n(rst_n),
        .fi(ov_if)
    );

    // ==========================================================
    // Unfiltered faults
    logic ot_q, ot_d;
    logic vcc_q, vcc_d;
    logic en_q, en_d;
    logic [EW-1:0] en_cnt_q, en_cnt_d;

    always_comb begin
        // Trip wins over recovery in the same cycle
        ot_d = ot_q;
        if (overtemp_trip) begin
            ot_d = 1'b1;
        end else if (overtemp_recovered) begin
            ot_d = 1'b0;
        end
        // Falling below lockout wins over the rising level
        vcc_d = vcc_q;
        if (vcc_below_lockout_hyst) begin
            vcc_d = 1'b1;
        end else if (vcc_above_lockout) begin
            vcc_d = 1'b0;
        end
        en_d = en_q;
        en_cnt_d = '0;
        if (!enable) begin
            en_d = 1'b1;
        end else if (en_q) begin
            if (en_cnt_q == EMAX) begin
                en_d = 1'b0;
            end else begin
                en_cnt_d = en_cnt_q + EW'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ot_q <= `FSUP_RST_FAULT;
            vcc_q <= `FSUP_RST_FAULT;
            en_q <= `FSUP_RST_FAULT;
            en_cnt_q <= '0;
        end else begin
            ot_q <= ot_d;
            vcc_q <= vcc_d;
            en_q <= en_d;
            en_cnt_q <= en_cnt_d;
        end
    end

    // ==========================================================
    // Soft start tracking
    // Started when the last of the overtemperature, lockout and enable faults
    // goes away; full output or the limit time ends it, whichever first.
    logic any_fault;
    logic stop_q, stop_d;
    logic ss_q, ss_d;
    logic [SSW-1:0] ss_cnt_q, ss_cnt_d;

    assign any_fault = uv_if.fault | ov_if.fault | ot_q | vcc_q | en_q;

    always_comb begin
        stop_d = ot_q | vcc_q | en_q;
        ss_d = ss_q;
        ss_cnt_d = ss_cnt_q;
        if (stop_q) begin
            ss_d = 1'b0;
            ss_cnt_d = '0;
        end else if (stop_q != stop_d) begin
            ss_d = 1'b0;
        end else if (ss_q) begin
            if (output_full || ss_cnt_q == SMAX) begin
                ss_d = 1'b0;
            end else begin
                ss_cnt_d = ss_cnt_q + SSW'(1);
            end
        end
        // A fresh release restarts soft start over the stop branch
        if (stop_q && !stop_d) begin
            ss_d = 1'b1;
            ss_cnt_d = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stop_q <= 1'b1;
            ss_q <= 1'b0;
            ss_cnt_q <= '0;
        end else begin
            stop_q <= stop_d;
            ss_q <= ss_d;
            ss_cnt_q <= ss_cnt_d;
        end
    end

    // ==========================================================
    // Release sequencing
    fsup_pkg::fsup_state_e st_q, st_d;
    logic [RW-1:0] rel_cnt_q, rel_cnt_d;
    logic oe_q, oe_d;
    logic swoff_q, swoff_d;
    logic pd_q, pd_d;

    always_comb begin
        st_d = st_q;
        rel_cnt_d = rel_cnt_q;
        unique case (st_q)
            fsup_pkg::FSUP_ST_FAULT: begin
                rel_cnt_d = '0;
                if (!any_fault) begin
                    st_d = fsup_pkg::FSUP_ST_DELAY;
                end
            end
            fsup_pkg::FSUP_ST_DELAY: begin
                if (rel_cnt_q == RMAX) begin
                    st_d = fsup_pkg::FSUP_ST_READY;
                end else begin
                    rel_cnt_d = rel_cnt_q + RW'(1);
                end
            end
            fsup_pkg::FSUP_ST_READY: begin
            end
            default: begin
                // Unused code falls back to holding reset
                st_d = fsup_pkg::FSUP_ST_FAULT;
            end
        endcase
        if (any_fault) begin
            st_d = fsup_pkg::FSUP_ST_FAULT;
            rel_cnt_d = '0;
        end
        // Soft start holds on its own, without the delay
        oe_d = (st_d != fsup_pkg::FSUP_ST_READY) || ss_d;
        // Below the minimum input the pull-down cannot be relied on
        if (!supply_input_ok) begin
            oe_d = 1'b0;
        end
        swoff_d = ov_if.fault;
        pd_d = ov_if.fault;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= fsup_pkg::FSUP_ST_FAULT;
            rel_cnt_q <= '0;
            oe_q <= `FSUP_RST_RESET_OE;
            swoff_q <= 1'b0;
            pd_q <= 1'b0;
        end else begin
            st_q <= st_d;
            rel_cnt_q <= rel_cnt_d;
            oe_q <= oe_d;
            swoff_q <= swoff_d;
            pd_q <= pd_d;
        end
    end

    // ==========================================================
    // Outputs
    logic drv_q;

    // Open drain: the pin only ever pulls low
    always_ff @(posedge mclk) begin
        drv_q <= 1'b0;
    end

    assign reset_o = drv_q;
    assign reset_oe = oe_q;
    assign switching_off = swoff_q;
    assign sw_pulldown_en = pd_q;
    assign softstart_active = ss_q;

    // ==========================================================
    // Checks
    rel_after_delay_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(oe_q) && $past(supply_input_ok) |->
        $past(st_q) == fsup_pkg::FSUP_ST_READY ||
        $past(rel_cnt_q) == RMAX)
        else $error("reset released before delay");
    en_low_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !enable ##1 supply_input_ok |=> oe_q)
        else $error("reset not driven while disabled");
    low_supply_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !supply_input_ok |=> !oe_q)
        else $error("reset driven below minimum supply");
    ov_shutdown_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ov_if.fault |=> switching_off && sw_pulldown_en)
        else $error("overvoltage did not stop switching");
    ot_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        overtemp_trip ##1 supply_input_ok |=> oe_q)
        else $error("reset released during overtemperature");
    en_startup_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(en_q) |-> $past(en_cnt_q) == EMAX && $past(enable))
        else $error("enable fault ended early");
    vcc_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        vcc_below_lockout_hyst |=> vcc_q)
        else $error("lockout fault not taken");
    ss_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ss_q && $past(supply_input_ok) |-> oe_q)
        else $error("reset released during soft start");
    ss_quick_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(ss_q) && st_q == fsup_pkg::FSUP_ST_READY && !any_fault &&
        $past(supply_input_ok) |-> !oe_q)
        else $error("soft start end did not release reset");
    rel_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
        any_fault |=> rel_cnt_q == '0 &&
        oe_q == $past(supply_input_ok))
        else $error("release timer not restarted by fault");

    // ==========================================================
    // Fault entry and exit checks, soft start limit and cancel checks
    uv_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        uv_if.fault && supply_input_ok |=> oe_q)
        else $error("reset released during undervoltage");
    ov_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ov_if.fault && supply_input_ok |=> oe_q)
        else $error("reset released during overvoltage");
    ov_release_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !ov_if.fault |=> !switching_off && !sw_pulldown_en)
        else $error("power stage held off without overvoltage");
    ot_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !overtemp_trip && overtemp_recovered |=> !ot_q)
        else $error("overtemperature fault not cleared");
    en_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !enable |=> en_q && en_cnt_q == '0)
        else $error("enable startup count not restarted");
    vcc_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !vcc_below_lockout_hyst && vcc_above_lockout |=> !vcc_q)
        else $error("lockout fault not cleared");
    ss_limit_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ss_q && ss_cnt_q == SMAX |=> !ss_q)
        else $error("soft start ran past its limit");
    ss_cancel_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ss_q && stop_d && !stop_q |=> !ss_q)
        else $error("soft start not cancelled by shutdown");
endmodule

// file: fsup_sys_model.sv
// System logic model that consumes the open-drain reset line
`timescale 1ns/1ps
module fsup_sys_model (
    // Clock
    input wire logic mclk,
    // Open-drain reset pin
    input wire logic reset_o,
    input wire logic reset_oe,
    // Observed state
    output logic sys_held,
    output logic drove_high
);
    logic line;
    // ==========================================================
    // Pin level, external pull-up when released
    assign line = reset_oe ? reset_o : 1'b1;
    assign sys_held = ~line;
    // Sticky flag: the pin may sink but never source
    initial drove_high = 1'b0;
    always @(posedge mclk) begin
        if (reset_oe === 1'b1 && reset_o !== 1'b0) begin
            drove_high <= 1'b1;
        end
    end
endmodule

// file: tb_supply_reset_supervisor.sv
// Self-checking bench of the supply reset supervisor
`timescale 1ns/1ps
module tb_supply_reset_supervisor;
    // Small counts keep the run short
    localparam int FC = 3;
    localparam int RC = 8;
    localparam int EC = 4;
    localparam int SC = 20;
    localparam int LIMIT = 3000;
    logic mclk, rst_n, fb_below_uv, fb_above_uv_hyst, fb_above_ov;
    logic fb_below_ov_hyst, overtemp_trip, overtemp_recovered, enable;
    logic vcc_below_lockout_hyst, vcc_above_lockout, supply_input_ok;
    logic output_full, reset_o, reset_oe, switching_off, sw_pulldown_en;
    logic softstart_active, sys_held, drove_high;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;

    fsup_top #(.FILT_CYC(FC), .REL_CYC(RC), .EN_CYC(EC), .SS_CYC(SC))
        fsup_top_inst (.*);
    fsup_sys_model fsup_sys_model_inst (.mclk(mclk), .reset_o(reset_o),
        .reset_oe(reset_oe), .sys_held(sys_held), .drove_high(drove_high));

    // ==========================================================
    // Clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            fail_count++;
            results();
        end
    end

    // ==========================================================
    // Compare helpers
    task automatic chk_bit(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_cnt(input string nm, input int lo, input int hi,
                           input int g);
        num_checks++;
        if (g < lo || g > hi) begin
            fail_count++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    // Bounded wait so a stuck pin shows as a count out of range
    task automatic wait_held(input string nm, input logic v, input int lo,
                             input int hi);
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (sys_held !== v && n <= hi);
        chk_cnt(nm, lo, hi, n);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_uv();
        @(posedge mclk);
        fb_below_uv <= 1'b1;
        fb_above_uv_hyst <= 1'b0;
        repeat (FC) @(posedge mclk);
        fb_below_uv <= 1'b0;
        idle(10);
        chk_bit("uv_short_pulse", 1'b0, sys_held);
        @(posedge mclk);
        fb_below_uv <= 1'b1;
        wait_held("uv_assert", 1'b1, FC + 1, FC + 6);
        @(posedge mclk);
        fb_below_uv <= 1'b0;
        idle(10);
        chk_bit("uv_in_hyst", 1'b1, sys_held);
        @(posedge mclk);
        fb_above_uv_hyst <= 1'b1;
        wait_held("uv_release", 1'b0, FC + RC + 1, FC + RC + 8);
    endtask
    task automatic t_ov();
        @(posedge mclk);
        fb_above_ov <= 1'b1;
        fb_below_ov_hyst <= 1'b0;
        wait_held("ov_assert", 1'b1, FC + 1, FC + 6);
        idle(2);
        chk_bit("ov_switch_off", 1'b1, switching_off);
        chk_bit("ov_pulldown", 1'b1, sw_pulldown_en);
        @(posedge mclk);
        fb_above_ov <= 1'b0;
        idle(10);
        chk_bit("ov_in_hyst", 1'b1, sys_held);
        @(posedge mclk);
        fb_below_ov_hyst <= 1'b1;
        wait_held("ov_release", 1'b0, FC + RC + 1, FC + RC + 8);
        chk_bit("ov_switch_on", 1'b0, switching_off);
    endtask
    task automatic t_en();
        @(posedge mclk);
        enable <= 1'b0;
        wait_held("en_low", 1'b1, 1, 5);
        @(posedge mclk);
        supply_input_ok <= 1'b0;
        wait_held("supply_low_float", 1'b0, 1, 4);
        @(posedge mclk);
        supply_input_ok <= 1'b1;
        wait_held("supply_back", 1'b1, 1, 4);
        @(posedge mclk);
        enable <= 1'b1;
        wait_held("en_release", 1'b0, EC + RC + 1, EC + RC + 10);
    endtask
    task automatic t_ot();
        @(posedge mclk);
        overtemp_trip <= 1'b1;
        overtemp_recovered <= 1'b0;
        wait_held("ot_assert", 1'b1, 1, 5);
        @(posedge mclk);
        overtemp_trip <= 1'b0;
        idle(10);
        chk_bit("ot_between", 1'b1, sys_held);
        @(posedge mclk);
        output_full <= 1'b0;
        overtemp_recovered <= 1'b1;
        idle(RC + 6);
        chk_bit("ss_hold", 1'b1, sys_held);
        chk_bit("ss_active", 1'b1, softstart_active);
        @(posedge mclk);
        output_full <= 1'b1;
        wait_held("ss_only_hold", 1'b0, 1, 4);
    endtask
    task automatic t_vcc();
        @(posedge mclk);
        vcc_below_lockout_hyst <= 1'b1;
        vcc_above_lockout <= 1'b0;
        wait_held("vcc_assert", 1'b1, 1, 5);
        @(posedge mclk);
        vcc_below_lockout_hyst <= 1'b0;
        idle(10);
        chk_bit("vcc_between", 1'b1, sys_held);
        @(posedge mclk);
        vcc_above_lockout <= 1'b1;
        wait_held("vcc_release", 1'b0, RC + 1, RC + 8);
    endtask

    // ==========================================================
    // Closing report
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        rst_n <= 1'b0;
        fb_below_uv <= 1'b0;
        fb_above_uv_hyst <= 1'b1;
        fb_above_ov <= 1'b0;
        fb_below_ov_hyst <= 1'b1;
        overtemp_trip <= 1'b0;
        overtemp_recovered <= 1'b1;
        enable <= 1'b1;
        vcc_below_lockout_hyst <= 1'b0;
        vcc_above_lockout <= 1'b1;
        supply_input_ok <= 1'b1;
        output_full <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        wait_held("powerup", 1'b0, SC, SC + EC + RC + 10);
        chk_bit("ss_done", 1'b0, softstart_active);
        @(posedge mclk);
        output_full <= 1'b1;
        t_uv();
        t_ov();
        t_en();
        t_ot();
        t_vcc();
        chk_bit("never_high", 1'b0, drove_high);
        results();
    end
endmodule
